// ===== host_bus_strap_config_regs.vh
// constants for the host bus strap and pin-function block
`ifndef HOST_BUS_STRAP_CONFIG_REGS_VH
`define HOST_BUS_STRAP_CONFIG_REGS_VH

// ==========================================================
// strap encodings
`define BUS_LAYOUT_SPLIT 1'h0
`define BUS_LAYOUT_GENERIC 1'h1
`define STROBE_STYLE_DIR_STB 1'h0
`define STROBE_STYLE_RD_WR 1'h1
`define ADDR_QUALIFY_ALE 1'h0
`define ADDR_QUALIFY_SELECT 1'h1

// ==========================================================
// timing
`define CORE_CLK_PERIOD_NS 50
`define STRAP_SETTLE_NS 200
`define STRAP_SETTLE_CYCLES ((`STRAP_SETTLE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define SETTLE_CNT_W 4
// synchroniser depth plus agreement stage, in cycles
`define STRAP_SYNC_CYCLES 4

// ==========================================================
// bit positions in the synchronised pin vector
`define SP_DATA_LSB 0
`define SP_AD_LSB 16
`define SP_PIN0 24
`define SP_PIN1 25
`define SP_QUAL 26
`define SP_P26 27
`define SP_P27 28
`define SP_CS_N 29
`define SP_SEL 30
`define SP_READY 31
`define SP_WIDTH 32
`define SP_RESET 32'hffff_ffff

`endif

// ===== pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter integer W = 1,
	parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [W-1:0] pin_i,
	output reg [W-1:0] sync_o
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer i;

	// ==========================================================
	// stages; s1 feeds only s2 so metastability stays contained
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_o[i] <= s3_q[i];
				end
			end
		end
	end

endmodule // pin_sync

`default_nettype wire

// ===== host_bus_strap_config.v
// strap capture and parallel host port pin-function selection
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_strap_config_regs.vh"


module host_bus_strap_config #(
	parameter integer SETTLE_CYCLES = `STRAP_SETTLE_CYCLES
) (
	input wire core_clk_i,
	input wire rst_n_i,
	// strap / task-file address pins
	input wire strap0_pin_i,
	output reg task_file_addr_bit0_o,
	output reg task_file_addr_bit0_oe_n_o,
	input wire strap1_pin_i,
	output reg task_file_addr_bit1_o,
	output reg task_file_addr_bit1_oe_n_o,
	output reg task_file_addr_bit2_o,
	input wire addr_qualify_strap_i,
	// host strobes
	input wire host_cs_n_i,
	input wire host_dir_rd_i,
	input wire host_strobe_wr_i,
	input wire addr_or_value_select_i,
	// byte lines
	input wire [7:0] ad_i,
	output reg [7:0] ad_o,
	output reg ad_oe_n_o,
	// word bus
	input wire [15:0] data_i,
	output reg [15:0] data_o,
	output reg data_oe_n_o,
	// shared ready pin
	input wire ready_i,
	output reg ready_o,
	output reg ready_oe_n_o,
	// core side
	output reg [7:0] reg_addr_o,
	output reg [15:0] reg_wdata_o,
	output reg reg_wr_o,
	output reg reg_rd_o,
	input wire [15:0] reg_rdata_i,
	input wire core_busy_i,
	input wire [2:0] ata_addr_i,
	input wire ata_access_i,
	output reg ata_iordy_o,
	input wire [15:0] dma_wdata_i,
	input wire dma_drive_i,
	output reg [15:0] dma_rdata_o,
	output reg straps_valid_o,
	output reg bus_layout_strap_o,
	output reg strobe_style_strap_o,
	output reg addr_qualify_strap_o
);

	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n;
	wire [`SP_WIDTH-1:0] sp;
	wire [15:0] s_data;
	wire [7:0] s_ad;
	reg state_q;
	reg [`SETTLE_CNT_W-1:0] settle_cnt_q;
	reg rd_act;
	reg wr_act;
	reg rd_prev_q;
	reg wr_prev_q;
	reg sel_prev_q;
	reg [7:0] ad_cap_q;
	reg [15:0] data_cap_q;
	reg sel_cap_q;
	reg rd_wait_q;
	wire generic;
	wire run;
	wire rd_start;
	wire wr_end;
	wire ale_fall;
	localparam [0:0] ST_SETTLE = 1'b0;
	localparam [0:0] ST_RUN = 1'b1;
	// count covers the synchroniser too, so a short settle still sees real pins
	localparam integer SETTLE_END = SETTLE_CYCLES + `STRAP_SYNC_CYCLES;

	// ==========================================================
	// reset release through two flip-flops
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ==========================================================
	// pin inputs
	pin_sync #(
		.W(`SP_WIDTH),
		.RESET_VAL(`SP_RESET)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.pin_i({ready_i, addr_or_value_select_i, host_cs_n_i, host_strobe_wr_i,
			host_dir_rd_i, addr_qualify_strap_i, strap1_pin_i, strap0_pin_i, ad_i, data_i}),
		.sync_o(sp)
	);
	assign s_data = sp[`SP_DATA_LSB +: 16];
	assign s_ad = sp[`SP_AD_LSB +: 8];

	// ==========================================================
	// strap capture; pins stay undriven until the values are held
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_SETTLE;
			settle_cnt_q <= {`SETTLE_CNT_W{1'b0}};
			straps_valid_o <= 1'b0;
			bus_layout_strap_o <= `BUS_LAYOUT_SPLIT;
			strobe_style_strap_o <= `STROBE_STYLE_DIR_STB;
			addr_qualify_strap_o <= `ADDR_QUALIFY_ALE;
		end else begin
			case (state_q)
			ST_SETTLE: begin
				// wait out the synchroniser so real pin levels are taken
				if (settle_cnt_q >= SETTLE_END[`SETTLE_CNT_W-1:0]) begin
					state_q <= ST_RUN;
					straps_valid_o <= 1'b1;
					bus_layout_strap_o <= sp[`SP_PIN0];
					strobe_style_strap_o <= sp[`SP_PIN1];
					addr_qualify_strap_o <= sp[`SP_QUAL];
				end else begin
					settle_cnt_q <= settle_cnt_q + 1'b1;
				end
			end
			default: begin
				// no path back: later pin activity cannot move the modes
				state_q <= ST_RUN;
			end
			endcase
		end
	end

	assign run = (state_q == ST_RUN);
	assign generic = (bus_layout_strap_o == `BUS_LAYOUT_GENERIC);

	// ==========================================================
	// strobe decode
	always @* begin
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (run && !sp[`SP_CS_N]) begin
			if (generic && strobe_style_strap_o == `STROBE_STYLE_DIR_STB) begin
				// direction high reads; data strobe times the access
				rd_act = !sp[`SP_P27] && sp[`SP_P26];
				wr_act = !sp[`SP_P27] && !sp[`SP_P26];
			end else begin
				// split mode always uses separate strobes
				rd_act = !sp[`SP_P26];
				wr_act = !sp[`SP_P27];
			end
		end
	end

	assign rd_start = rd_act && !rd_prev_q;
	assign wr_end = !wr_act && wr_prev_q;
	assign ale_fall = run && !generic && addr_qualify_strap_o == `ADDR_QUALIFY_ALE &&
		sel_prev_q && !sp[`SP_SEL];

	// ==========================================================
	// register access toward the core
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			sel_prev_q <= 1'b0;
			ad_cap_q <= 8'h00;
			data_cap_q <= 16'h0000;
			sel_cap_q <= 1'b0;
			rd_wait_q <= 1'b0;
			reg_addr_o <= 8'h00;
			reg_wdata_o <= 16'h0000;
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
		end else begin
			rd_prev_q <= rd_act;
			wr_prev_q <= wr_act;
			sel_prev_q <= sp[`SP_SEL];
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			rd_wait_q <= rd_start;
			// last level before the strobe rises is the one taken
			if (wr_act) begin
				ad_cap_q <= s_ad;
				data_cap_q <= s_data;
				sel_cap_q <= sp[`SP_SEL];
			end
			if (ale_fall) begin
				reg_addr_o <= s_ad;
			end
			if (rd_start) begin
				reg_rd_o <= 1'b1;
				if (generic) begin
					reg_addr_o <= s_ad;
				end
			end
			if (wr_end) begin
				if (generic) begin
					reg_addr_o <= ad_cap_q;
					reg_wdata_o <= data_cap_q;
					reg_wr_o <= 1'b1;
				end else if (addr_qualify_strap_o == `ADDR_QUALIFY_SELECT && sel_cap_q) begin
					reg_addr_o <= ad_cap_q;
				end else begin
					reg_wdata_o <= {8'h00, ad_cap_q};
					reg_wr_o <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// pin drivers; enables are low while driving
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			task_file_addr_bit0_o <= 1'b0;
			task_file_addr_bit0_oe_n_o <= 1'b1;
			task_file_addr_bit1_o <= 1'b0;
			task_file_addr_bit1_oe_n_o <= 1'b1;
			task_file_addr_bit2_o <= 1'b0;
			ad_o <= 8'h00;
			ad_oe_n_o <= 1'b1;
			data_o <= 16'h0000;
			data_oe_n_o <= 1'b1;
			ready_o <= 1'b0;
			ready_oe_n_o <= 1'b1;
			ata_iordy_o <= 1'b1;
			dma_rdata_o <= 16'h0000;
		end else begin
			task_file_addr_bit0_o <= ata_addr_i[0];
			task_file_addr_bit1_o <= ata_addr_i[1];
			task_file_addr_bit2_o <= ata_addr_i[2];
			task_file_addr_bit0_oe_n_o <= !run;
			task_file_addr_bit1_oe_n_o <= !run;
			dma_rdata_o <= s_data;
			ad_oe_n_o <= 1'b1;
			data_oe_n_o <= 1'b1;
			if (generic) begin
				// register reads take priority over dma on the shared word bus
				if (rd_act) begin
					data_o <= reg_rdata_i;
					data_oe_n_o <= 1'b0;
				end else if (dma_drive_i && run) begin
					data_o <= dma_wdata_i;
					data_oe_n_o <= 1'b0;
				end
				ready_oe_n_o <= !run;
				ready_o <= run && !core_busy_i && !rd_wait_q && !wr_end;
				ata_iordy_o <= 1'b1;
			end else begin
				if (rd_act) begin
					ad_o <= reg_rdata_i[7:0];
					ad_oe_n_o <= 1'b0;
				end
				if (dma_drive_i && run) begin
					data_o <= dma_wdata_i;
					data_oe_n_o <= 1'b0;
				end
				ready_oe_n_o <= 1'b1;
				ready_o <= 1'b0;
				// iordy only matters during peripheral accesses
				ata_iordy_o <= ata_access_i ? sp[`SP_READY] : 1'b1;
			end
		end
	end

endmodule // host_bus_strap_config

`default_nettype wire

// ===== host_bus_strap_config_checker.sv
// assertion checker for the host bus strap block
`timescale 1ns/1ps
`default_nettype none
module host_bus_strap_config_checker (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic straps_valid_o,
	input wire logic bus_layout_strap_o,
	input wire logic strobe_style_strap_o,
	input wire logic [2:0] ata_addr_i,
	input wire logic task_file_addr_bit2_o,
	input wire logic task_file_addr_bit0_oe_n_o,
	input wire logic ready_oe_n_o,
	input wire logic ready_o,
	input wire logic core_busy_i,
	input wire logic ad_oe_n_o,
	input wire logic reg_wr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// pin functions after strap capture
	a_straps_held: assert property ($past(straps_valid_o) |->
		$stable({bus_layout_strap_o, strobe_style_strap_o})) else $error("strap moved");
	a_tf_addr: assert property ($past(straps_valid_o) |->
		task_file_addr_bit2_o == $past(ata_addr_i[2])) else $error("bit2 wrong");
	a_tf_drive: assert property ($past(straps_valid_o) |->
		!task_file_addr_bit0_oe_n_o) else $error("bit0 undriven");
	a_split_ready: assert property (straps_valid_o && !bus_layout_strap_o |->
		ready_oe_n_o) else $error("ready driven");
	a_gen_ready: assert property ($past(straps_valid_o) && bus_layout_strap_o |->
		!ready_oe_n_o) else $error("ready undriven");
	a_busy_ready: assert property ((bus_layout_strap_o && core_busy_i) [*3] |->
		!ready_o) else $error("ready while busy");
	a_byte_free: assert property (straps_valid_o && bus_layout_strap_o |->
		ad_oe_n_o) else $error("byte lines driven");
	a_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o) else $error("long wr");
endmodule // host_bus_strap_config_checker
bind host_bus_strap_config host_bus_strap_config_checker i_chk (.*);
`default_nettype wire

// ===== host_model.sv
// host processor model for the parallel port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic [15:0] data_i,
	output logic cs_n_o,
	output logic p26_o,
	output logic p27_o,
	output logic sel_o,
	output logic [7:0] ad_o,
	output logic [15:0] data_o
);
	initial begin
		{cs_n_o, p26_o, p27_o, sel_o} = 4'he;
		ad_o = 8'h00;
		data_o = 16'h0000;
	end
	// phases of 8 cycles clear the pin synchronisers; released lines flip
	task automatic acc(input logic dsm, rd, s, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		while (ready_i !== 1'b1) begin
			@(posedge clk_i);
			if (++n > 200) tb_host_bus_strap_config.fail_out;
		end
		@(posedge clk_i);
		{cs_n_o, sel_o, ad_o, data_o} <= {1'h0, s, a, d};
		p26_o <= dsm ? rd : !rd;
		p27_o <= dsm ? 1'h0 : rd;
		repeat (8) @(posedge clk_i);
		q = data_i;
		p27_o <= 1'h1;
		p26_o <= dsm ? rd : 1'h1;
		repeat (8) @(posedge clk_i);
		{cs_n_o, p26_o, ad_o, data_o} <= {2'h3, ~a, ~d};
	endtask
	task automatic ale(input logic [7:0] a);
		@(posedge clk_i);
		{cs_n_o, sel_o, ad_o} <= {2'h1, a};
		repeat (8) @(posedge clk_i);
		sel_o <= 1'h0;
		repeat (8) @(posedge clk_i);
		{cs_n_o, ad_o} <= {1'h1, ~a};
	endtask
endmodule // host_model
`default_nettype wire

// ===== tb_host_bus_strap_config.sv
// self-checking bench for the host bus strap block
`timescale 1ns/1ps
`default_nettype none
module tb_host_bus_strap_config;
	logic core_clk_i = 0;
	logic rst_n_i = 0;
	logic s0, s1, addr_qualify_strap_i, core_busy_i, ata_access_i, dma_drive_i, io;
	logic [2:0] ata_addr_i;
	logic [15:0] reg_rdata_i, dma_wdata_i, q;
	logic [23:0] got[$];
	int mismatches = 0;
	int checks_done = 0;
	int reads = 0;
	wire task_file_addr_bit0_o, task_file_addr_bit0_oe_n_o, task_file_addr_bit1_o;
	wire task_file_addr_bit1_oe_n_o, task_file_addr_bit2_o, ad_oe_n_o, data_oe_n_o;
	wire ready_o, ready_oe_n_o, reg_wr_o, reg_rd_o, ata_iordy_o, straps_valid_o;
	wire bus_layout_strap_o, strobe_style_strap_o, addr_qualify_strap_o;
	wire host_cs_n_i, host_dir_rd_i, host_strobe_wr_i, addr_or_value_select_i;
	wire [7:0] ad_o, reg_addr_o, ha;
	wire [15:0] data_o, reg_wdata_o, dma_rdata_o, hd;
	wire strap0_pin_i = task_file_addr_bit0_oe_n_o ? s0 : task_file_addr_bit0_o;
	wire strap1_pin_i = task_file_addr_bit1_oe_n_o ? s1 : task_file_addr_bit1_o;
	wire [7:0] ad_i = ad_oe_n_o ? ha : ad_o;
	wire [15:0] data_i = data_oe_n_o ? hd : data_o;
	wire ready_i = ready_oe_n_o ? io : ready_o;
	always #25 core_clk_i = ~core_clk_i;
	host_model i_host (.clk_i(core_clk_i), .ready_i(ready_i), .data_i(data_i),
		.cs_n_o(host_cs_n_i), .p26_o(host_dir_rd_i), .p27_o(host_strobe_wr_i),
		.sel_o(addr_or_value_select_i), .ad_o(ha), .data_o(hd));
	host_bus_strap_config #(.SETTLE_CYCLES(1)) i_dut (.*);
	always @(posedge core_clk_i) if (reg_wr_o === 1'b1) got.push_back({reg_addr_o, reg_wdata_o});
	always @(posedge core_clk_i) if (reg_rd_o === 1'b1) reads++;
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task fail_out;
		mismatches++;
		report_and_stop;
	endtask
	task wchk(input logic [23:0] e);
		chk("writes", 24'h1, 24'(got.size()));
		chk("write", e, got[0]);
		got.delete();
	endtask
	task run(input logic b, m, k);
		logic [7:0] a;
		logic [15:0] d;
		int n;
		a = $urandom;
		d = $urandom;
		n = 0;
		reads = 0;
		@(posedge core_clk_i);
		{s0, s1, addr_qualify_strap_i, rst_n_i} <= {b, m, k, 1'h0};
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		while (straps_valid_o !== 1'b1) begin
			@(posedge core_clk_i);
			if (++n > 50) fail_out;
		end
		ata_addr_i <= a[2:0];
		repeat (3) @(posedge core_clk_i);
		chk("straps", {b, m, k}, {bus_layout_strap_o, strobe_style_strap_o,
			addr_qualify_strap_o});
		chk("tf addr", {2'h0, a[2:0]}, {task_file_addr_bit1_oe_n_o,
			task_file_addr_bit0_oe_n_o, task_file_addr_bit2_o, task_file_addr_bit1_o,
			task_file_addr_bit0_o});
		if (b) begin
			i_host.acc(!m, 1'h0, 1'h0, a, d, q);
			wchk({a, d});
			reg_rdata_i <= ~d;
			i_host.acc(!m, 1'h1, 1'h0, ~a, d, q);
			chk("read", {~a, ~d}, {reg_addr_o, q});
			core_busy_i <= 1'h1;
			repeat (4) @(posedge core_clk_i);
			chk("busy ready", 24'h0, {ready_oe_n_o, ready_o});
			core_busy_i <= 1'h0;
		end else begin
			if (k) i_host.acc(1'h0, 1'h0, 1'h1, a, 16'h0000, q);
			else i_host.ale(a);
			i_host.acc(1'h0, 1'h0, 1'h0, d[7:0], 16'h0000, q);
			wchk({a, 8'h00, d[7:0]});
			reg_rdata_i <= ~d;
			i_host.acc(1'h0, 1'h1, 1'h0, ~a, 16'h0000, q);
			chk("byte read", {16'h0, ~d[7:0]}, {16'h0, ad_o});
			{ata_access_i, io, dma_drive_i, dma_wdata_i} <= {3'h5, d};
			repeat (8) @(posedge core_clk_i);
			chk("iordy dma", {2'h0, d}, {ata_iordy_o, data_oe_n_o, data_o});
			chk("dma echo", {8'h0, d}, {8'h0, dma_rdata_o});
			{ata_access_i, io, dma_drive_i} <= 3'h2;
		end
		chk("reads", 24'h1, 24'(reads));
		$display("mode %b%b%b done", b, m, k);
	endtask
	initial begin
		{s0, s1, addr_qualify_strap_i, core_busy_i, ata_access_i, dma_drive_i, io} = 7'h01;
		ata_addr_i = 3'h0;
		reg_rdata_i = 16'h0000;
		dma_wdata_i = 16'h0000;
		void'($urandom(52511));
		run(1'h1, 1'h1, 1'h1);
		run(1'h1, 1'h0, 1'h1);
		run(1'h0, 1'h1, 1'h1);
		run(1'h0, 1'h1, 1'h0);
		report_and_stop;
	end
endmodule // tb_host_bus_strap_config
`default_nettype wire
